// ### llf_params.svh
// register map, field positions, encodings and timing for the lapb link frame control block
`ifndef LLF_PARAMS_SVH
`define LLF_PARAMS_SVH
`define LLF_OFS_CTRL    4'h0
`define LLF_OFS_STAT    4'h1
`define LLF_OFS_TXDATA  4'h2
`define LLF_OFS_SEQ     4'h3
`define LLF_OFS_TXLEN   4'h4
`define LLF_OFS_RXCTRL  4'h7
`define LLF_OFS_TMR_LO  4'h8
`define LLF_OFS_TMR_HI  4'h9
`define LLF_OFS_LADDR   4'he
`define LLF_OFS_RADDR   4'hf
`define LLF_CB_SEND     0
`define LLF_CB_RESP     1
`define LLF_CB_LOOP     3
`define LLF_CB_POLL     7
`define LLF_SB_BUSY     0
`define LLF_SB_TRUN     1
`define LLF_SB_ERR      2
`define LLF_SB_RXCMD    3
`define LLF_SB_RXABT    4
`define LLF_SB_FULL     5
`define LLF_SB_EMPTY    6
`define LLF_SB_RXOK     7
`define LLF_FLAG        8'h7e
`define LLF_ABORT       8'hff
`define LLF_PF_MASK     8'h10
`define LLF_S_RR        4'h1
`define LLF_S_RNR       4'h5
`define LLF_S_REJ       4'h9
`define LLF_U_SABM_HI   3'h1
`define LLF_U_SABM_LO   4'hf
`define LLF_U_DISC_HI   3'h2
`define LLF_U_DISC_LO   4'h3
`define LLF_U_UA_HI     3'h3
`define LLF_U_UA_LO     4'h3
`define LLF_U_DM_HI     3'h0
`define LLF_U_DM_LO     4'hf
`define LLF_STUFF_ONES  3'h5
`define LLF_FLAG_ONES   3'h6
`define LLF_CLK_HZ      20000000
`define LLF_TICK_CLKS   16384
`define LLF_SYNC_RST    18'h38000
`endif

// ### llf_pkg.sv
// types shared by the lapb link frame control block
package llf_pkg;
  typedef enum logic [2:0] {K_I, K_RR, K_RNR, K_REJ, K_SABM, K_DISC, K_UA, K_DM} llf_kind_t;
  typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_ADDR, TX_CTRL, TX_DATA, TX_CLOSE, TX_ABORT} llf_tx_state_t;
endpackage

// ### llf_link_frame_control.sv
// lapb link frame control: cpu registers, framer, deframer, response timer
// Functional notes
// RULE1 - two programmable address registers set link addresses
// RULE2 - host loads 01/03 as dte, 03/01 dce
// RULE3 - loopback testing uses equal address registers
// RULE4 - address picks command or response role
// RULE5 - timer starts on command unless running
// RULE6 - expiry resends with poll, error past limit
// RULE7 - exhausted: sabm, disc, or disc forever
// RULE8 - info control: 0, ns, poll, nr
// RULE9 - unnumbered control byte encodings, p/f bit4
// RULE10 - supervisory control: nr, p/f, rr/rnr/rej nibble
// RULE11 - rej sent only as response, accepted both
// RULE12 - seven ones abort, receiver discards frame
// RULE13 - abort on underrun or rej during info
// RULE14 - internal loopback routes tx data and clock
// RULE15 - external loopback needs outside tx-rx connection
// RULE16 - master reset held at least 10 ms
// RULE17 - no host access 500 ns after ack
// RULE18 - no ack edge 500 ns after write
// RULE19 - 10-bit timer, 6-bit limit, retained
// RULE20 - timer unit is 16384 clock periods
`timescale 1ns/100ps
`default_nettype none
`include "llf_params.svh"

// transmit byte buffer
module llf_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk,       // system clock
  input  wire logic         rst_n,     // async reset, low
  input  wire logic         in_valid,  // push request
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // pushed word
  output logic              out_valid, // word available
  input  wire logic         out_ready, // pop request
  output logic [W-1:0]      out_data   // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];      // storage
  logic [AW:0]  wp_reg;       // write pointer, extra wrap bit
  logic [AW:0]  rp_reg;       // read pointer, extra wrap bit
  logic         push;
  logic         pop;
  assign in_ready  = (wp_reg - rp_reg) != (AW+1)'(D);
  assign out_valid = wp_reg != rp_reg;
  assign out_data  = mem[rp_reg[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // storage has no reset, pointers qualify it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end
  // pointer update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop)  rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule

module llf_link_frame_control #(
  parameter int TICK_CLKS = `LLF_TICK_CLKS // timer unit in clocks
) (
  input  wire logic       CLOCK,          // 20 mhz system clock
  input  wire logic       RESET_N,        // master reset, low
  input  wire logic       CS_N,           // chip select, low
  input  wire logic       RE_N,           // read strobe, low
  input  wire logic       WE_N,           // write strobe, low
  input  wire logic [3:0] ADDR,           // register address
  input  wire logic [7:0] DATA_IN,        // cpu write data
  output logic      [7:0] DATA_OUT,       // cpu read data
  output logic            DATA_OE,        // read data drive enable
  input  wire logic       TX_BIT_CLOCK,   // transmit bit clock pin
  input  wire logic       RX_BIT_CLOCK,   // receive bit clock pin
  input  wire logic       SERIAL_RX_DATA, // receive data pin
  output logic            SERIAL_TX_DATA, // transmit data pin
  output logic            LINK_ERROR,     // retries exhausted, sticky
  output logic            TX_BUSY         // framer active
);
  import llf_pkg::*;

  // pin synchronisers: stage one feeds stage two only
  logic [17:0] sy1_reg;
  logic [17:0] sy2_reg;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sy1_reg <= `LLF_SYNC_RST;
      sy2_reg <= `LLF_SYNC_RST;
    end else begin
      sy1_reg <= {CS_N, RE_N, WE_N, ADDR, DATA_IN, TX_BIT_CLOCK, RX_BIT_CLOCK, SERIAL_RX_DATA};
      sy2_reg <= sy1_reg;
    end
  end
  logic       cs_n_s, re_n_s, we_n_s, tck_s, rck_s, rxd_s;
  logic [3:0] adr_s;
  logic [7:0] din_s;
  assign {cs_n_s, re_n_s, we_n_s, adr_s, din_s, tck_s, rck_s, rxd_s} = sy2_reg;

  logic [7:0] ctrl_reg;   // send, resp, loopback, kind, poll
  // previous samples for strobe and clock edges
  logic       cs_n_p_reg, we_n_p_reg, tck_p_reg, rck_p_reg;
  logic [3:0] adr_p_reg;
  logic [7:0] din_p_reg;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_n_p_reg <= 1'b1;
      we_n_p_reg <= 1'b1;
      tck_p_reg  <= 1'b0;
      rck_p_reg  <= 1'b0;
      adr_p_reg  <= '0;
      din_p_reg  <= '0;
    end else begin
      cs_n_p_reg <= cs_n_s;
      we_n_p_reg <= we_n_s;
      tck_p_reg  <= tck_s;
      rck_p_reg  <= (ctrl_reg[`LLF_CB_LOOP]) ? tck_s : rck_s;
      adr_p_reg  <= adr_s;
      din_p_reg  <= din_s;
    end
  end
  // write is taken at the trailing edge of the write strobe
  logic wr_stb;
  assign wr_stb = ~cs_n_p_reg & ~we_n_p_reg & we_n_s;

  // cpu registers
  logic [7:0] seq_reg;    // nr in 7:5, ns in 2:0
  logic [7:0] txlen_reg;  // info bytes of next frame
  logic [7:0] tmr_lo_reg; // timer preset low bits
  logic [7:0] tmr_hi_reg; // retry limit 7:2, timer preset 9:8
  logic [7:0] laddr_reg;  // local link address
  logic [7:0] raddr_reg;  // remote link address
  logic [7:0] rxc_reg;    // last accepted control byte
  logic       err_reg;    // sticky link error
  logic       rxcmd_reg;  // last frame was a command
  logic       rxabt_reg;  // an abort was seen
  logic       rxok_reg;   // a frame has been accepted
  logic       hw_take;    // framer consumed the send request
  logic       exp_err;    // retries exhausted this cycle
  logic       rx_end_ok;  // good frame ended this cycle
  logic       rx_abort;   // abort seen this cycle

  // plain registers, kept until rewritten or reset
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      seq_reg    <= '0;
      txlen_reg  <= '0;
      tmr_lo_reg <= '0;
      tmr_hi_reg <= '0;
      laddr_reg  <= '0;
      raddr_reg  <= '0;
    end else if (wr_stb) begin
      case (adr_p_reg)
        `LLF_OFS_SEQ:    seq_reg    <= din_p_reg;
        `LLF_OFS_TXLEN:  txlen_reg  <= din_p_reg;
        `LLF_OFS_TMR_LO: tmr_lo_reg <= din_p_reg; // RULE19
        `LLF_OFS_TMR_HI: tmr_hi_reg <= din_p_reg; // RULE19
        `LLF_OFS_LADDR:  laddr_reg  <= din_p_reg; // RULE1
        `LLF_OFS_RADDR:  raddr_reg  <= din_p_reg; // RULE1
        default: ;
      endcase
    end
  end

  // control: cpu sets send, framer clears it; a new set wins
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= '0;
    end else if (wr_stb && adr_p_reg == `LLF_OFS_CTRL) begin
      ctrl_reg <= din_p_reg;
    end else if (hw_take) begin
      ctrl_reg[`LLF_CB_SEND] <= 1'b0;
    end
  end

  // status flags: hardware set wins over a write-one clear
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      err_reg   <= 1'b0;
      rxabt_reg <= 1'b0;
    end else begin
      if (exp_err) begin
        err_reg <= 1'b1;
      end else if (wr_stb && adr_p_reg == `LLF_OFS_STAT && din_p_reg[`LLF_SB_ERR]) begin
        err_reg <= 1'b0;
      end
      if (rx_abort) begin
        rxabt_reg <= 1'b1;
      end else if (wr_stb && adr_p_reg == `LLF_OFS_STAT && din_p_reg[`LLF_SB_RXABT]) begin
        rxabt_reg <= 1'b0;
      end
    end
  end

  // transmit buffer, filled through the data register
  logic       fifo_rdy, fifo_val, fifo_pop;
  logic [7:0] fifo_dat;
  llf_fifo #(.W(8), .D(32)) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RESET_N),
    .in_valid  (wr_stb && adr_p_reg == `LLF_OFS_TXDATA),
    .in_ready  (fifo_rdy),
    .in_data   (din_p_reg),
    .out_valid (fifo_val),
    .out_ready (fifo_pop),
    .out_data  (fifo_dat)
  );

  // control byte builder
  function automatic logic [7:0] cbyte(input llf_kind_t k, input logic pf, input logic [7:0] sq);
    case (k)
      K_I:     cbyte = {sq[7:5], pf, sq[2:0], 1'b0};            // RULE8
      K_RR:    cbyte = {sq[7:5], pf, `LLF_S_RR};                // RULE10
      K_RNR:   cbyte = {sq[7:5], pf, `LLF_S_RNR};               // RULE10
      K_REJ:   cbyte = {sq[7:5], pf, `LLF_S_REJ};               // RULE10
      K_SABM:  cbyte = {`LLF_U_SABM_HI, pf, `LLF_U_SABM_LO};    // RULE9
      K_DISC:  cbyte = {`LLF_U_DISC_HI, pf, `LLF_U_DISC_LO};    // RULE9
      K_UA:    cbyte = {`LLF_U_UA_HI, pf, `LLF_U_UA_LO};        // RULE9
      default: cbyte = {`LLF_U_DM_HI, pf, `LLF_U_DM_LO};        // RULE9
    endcase
  endfunction

  // requested frame; rej and ua/dm always go as responses
  llf_kind_t req_kind;
  logic      req_cmd;
  assign req_kind = llf_kind_t'(ctrl_reg[6:4]);
  assign req_cmd  = (req_kind == K_I || req_kind == K_SABM || req_kind == K_DISC ||
                     ((req_kind == K_RR || req_kind == K_RNR) && !ctrl_reg[`LLF_CB_RESP])); // RULE11

  // timer and retry state
  logic       rt_run_reg;   // response timer running
  logic [9:0] rt_cnt_reg;   // units left
  logic [15:0] tick_reg;    // clocks inside one unit
  logic [5:0] retry_reg;    // retransmissions so far
  logic       retx_reg;     // hardware frame pending
  llf_kind_t  retx_kind_reg; // kind of pending hardware frame
  llf_kind_t  cmd_kind_reg; // kind of outstanding command
  logic       rx_resp;      // response received this cycle
  logic       tx_cmd_start; // command framing starts this cycle
  logic       tick;
  assign tick = (tick_reg == 16'(TICK_CLKS - 1));

  // response timer: unit of TICK_CLKS clocks, preset in units
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rt_run_reg <= 1'b0;
      rt_cnt_reg <= '0;
      tick_reg   <= '0;
    end else if (rx_resp) begin
      rt_run_reg <= 1'b0;
    end else if (tx_cmd_start && !rt_run_reg) begin
      rt_run_reg <= 1'b1;                                     // RULE5
      rt_cnt_reg <= {tmr_hi_reg[1:0], tmr_lo_reg};            // RULE19
      tick_reg   <= '0;
    end else if (rt_run_reg) begin
      tick_reg <= tick ? '0 : tick_reg + 1'b1;                // RULE20
      if (tick) begin
        rt_cnt_reg <= rt_cnt_reg - 1'b1;
        if (rt_cnt_reg <= 10'h001) rt_run_reg <= 1'b0;
      end
    end
  end
  logic expire;
  assign expire  = rt_run_reg && tick && rt_cnt_reg <= 10'h001 && !rx_resp;
  assign exp_err = expire && retry_reg >= tmr_hi_reg[7:2];

  // retry handling and recovery frame choice
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      retry_reg     <= '0;
      retx_reg      <= 1'b0;
      retx_kind_reg <= K_RR;
    end else begin
      if (hw_take && retx_reg) retx_reg <= 1'b0;
      if (rx_resp) begin
        retry_reg <= '0;
      end else if (exp_err) begin
        retry_reg <= '0;                                      // RULE7
        retx_reg  <= 1'b1;
        case (cmd_kind_reg)
          K_SABM:  retx_kind_reg <= K_DISC;                   // RULE7
          K_DISC:  retx_kind_reg <= K_DISC;                   // RULE7
          default: retx_kind_reg <= K_SABM;                   // RULE7
        endcase
      end else if (expire) begin
        retry_reg <= retry_reg + 1'b1;                        // RULE6
        retx_reg  <= 1'b1;
        // an info frame is polled again as rr, its data is gone
        retx_kind_reg <= (cmd_kind_reg == K_I) ? K_RR : cmd_kind_reg; // RULE6
      end
    end
  end

  // framer
  llf_tx_state_t tx_st_reg;
  logic [7:0] sh_reg;     // bits left in current byte
  logic [2:0] bit_reg;    // bit index in byte
  logic [2:0] ones_reg;   // consecutive ones sent
  logic [7:0] left_reg;   // info bytes left
  logic [7:0] ctl_reg;    // control byte of this frame
  logic [7:0] adr_reg;    // address byte of this frame
  logic       rej_reg;    // rej arrived during info field
  logic       tck_fall;
  logic       stuff;
  logic       rej_hit;
  assign tck_fall = tck_p_reg & ~tck_s;
  assign stuff    = (tx_st_reg == TX_ADDR || tx_st_reg == TX_CTRL || tx_st_reg == TX_DATA ||
                     (tx_st_reg == TX_CLOSE && bit_reg == 3'h0)) && ones_reg == `LLF_STUFF_ONES;
  assign hw_take  = tck_fall && tx_st_reg == TX_IDLE && (retx_reg || ctrl_reg[`LLF_CB_SEND]);
  assign tx_cmd_start = hw_take && (retx_reg || req_cmd);    // RULE5
  assign fifo_pop = tck_fall && !stuff && bit_reg == 3'h7 && left_reg != 8'h00 && fifo_val &&
                    (tx_st_reg == TX_CTRL || tx_st_reg == TX_DATA);

  // rej seen while sending info ends the frame with an abort
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rej_reg <= 1'b0;
    end else if (rej_hit && tx_st_reg == TX_DATA) begin
      rej_reg <= 1'b1;                                        // RULE13
    end else if (tx_st_reg != TX_DATA) begin
      rej_reg <= 1'b0;
    end
  end

  // bit sequencer, advanced on each falling transmit clock
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_st_reg      <= TX_IDLE;
      sh_reg         <= '0;
      bit_reg        <= '0;
      ones_reg       <= '0;
      left_reg       <= '0;
      ctl_reg        <= '0;
      adr_reg        <= '0;
      cmd_kind_reg   <= K_RR;
      SERIAL_TX_DATA <= 1'b1;
    end else if (tck_fall) begin
      if (tx_st_reg == TX_IDLE) begin
        SERIAL_TX_DATA <= 1'b1;                               // idle mark
        if (hw_take) begin
          tx_st_reg <= TX_OPEN;
          sh_reg    <= `LLF_FLAG;
          bit_reg   <= '0;
          if (retx_reg) begin
            ctl_reg      <= cbyte(retx_kind_reg, 1'b1, seq_reg); // RULE6
            adr_reg      <= laddr_reg;                         // RULE4
            left_reg     <= '0;
            cmd_kind_reg <= retx_kind_reg;
          end else begin
            ctl_reg  <= cbyte(req_kind, ctrl_reg[`LLF_CB_POLL], seq_reg);
            adr_reg  <= req_cmd ? laddr_reg : raddr_reg;       // RULE4
            left_reg <= (req_kind == K_I) ? txlen_reg : 8'h00;
            if (req_cmd) cmd_kind_reg <= req_kind;
          end
        end
      end else if (rej_reg) begin
        tx_st_reg <= TX_ABORT;                                // RULE13
        sh_reg    <= `LLF_ABORT;
        bit_reg   <= '0;
      end else if (stuff) begin
        SERIAL_TX_DATA <= 1'b0;                               // inserted zero
        ones_reg       <= '0;
      end else begin
        SERIAL_TX_DATA <= sh_reg[0];
        sh_reg         <= {1'b0, sh_reg[7:1]};
        bit_reg        <= bit_reg + 1'b1;
        ones_reg       <= sh_reg[0] ? ones_reg + 1'b1 : 3'h0;
        if (bit_reg == 3'h7) begin
          case (tx_st_reg)
            TX_OPEN: begin
              tx_st_reg <= TX_ADDR;
              sh_reg    <= adr_reg;
              ones_reg  <= '0;
            end
            TX_ADDR: begin
              tx_st_reg <= TX_CTRL;
              sh_reg    <= ctl_reg;
            end
            TX_CTRL, TX_DATA: begin
              if (left_reg == 8'h00) begin
                tx_st_reg <= TX_CLOSE;
                sh_reg    <= `LLF_FLAG;
              end else if (!fifo_val) begin
                tx_st_reg <= TX_ABORT;                        // RULE13
                sh_reg    <= `LLF_ABORT;                      // RULE12
              end else begin
                tx_st_reg <= TX_DATA;
                sh_reg    <= fifo_dat;
                left_reg  <= left_reg - 1'b1;
              end
            end
            default: tx_st_reg <= TX_IDLE;                    // flag or abort done
          endcase
        end
      end
    end
  end

  // deframer, on rising receive clock; loopback takes tx pins
  logic       rx_bit;
  logic       rck_rise;
  logic [2:0] r_ones_reg;  // consecutive ones received
  logic [2:0] r_bit_reg;   // bit index in byte
  logic [7:0] r_sh_reg;    // assembling byte
  logic [1:0] r_cnt_reg;   // bytes so far, saturating
  logic       r_in_reg;    // inside a frame
  logic [7:0] r_adr_reg;   // received address
  logic [7:0] r_ctl_reg;   // received control
  logic       a_loc, a_rem;
  assign rx_bit   = ctrl_reg[`LLF_CB_LOOP] ? SERIAL_TX_DATA : rxd_s;   // RULE14
  assign rck_rise = ~rck_p_reg & (ctrl_reg[`LLF_CB_LOOP] ? tck_s : rck_s); // RULE14
  assign rx_abort = rck_rise && rx_bit && r_ones_reg == `LLF_FLAG_ONES;    // RULE12
  assign rx_end_ok = rck_rise && !rx_bit && r_ones_reg == `LLF_FLAG_ONES && r_in_reg &&
                     r_bit_reg == 3'h7 && r_cnt_reg == 2'h2 && (a_loc || a_rem);
  assign a_loc    = r_adr_reg == laddr_reg;
  assign a_rem    = r_adr_reg == raddr_reg;
  assign rx_resp  = rx_end_ok && a_loc;                               // RULE4
  assign rej_hit  = rx_end_ok && r_ctl_reg[3:0] == `LLF_S_REJ;         // RULE11

  // byte assembly with zero deletion and flag hunt
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_ones_reg <= '0;
      r_bit_reg  <= '0;
      r_sh_reg   <= '0;
      r_cnt_reg  <= '0;
      r_in_reg   <= 1'b0;
      r_adr_reg  <= '0;
      r_ctl_reg  <= '0;
    end else if (rck_rise) begin
      r_ones_reg <= rx_bit ? ((r_ones_reg == 3'h7) ? r_ones_reg : r_ones_reg + 1'b1) : 3'h0;
      if (rx_abort) begin
        r_in_reg <= 1'b0;                                     // RULE12
      end else if (!rx_bit && r_ones_reg == `LLF_FLAG_ONES) begin
        r_in_reg  <= 1'b1;                                    // flag opens next frame
        r_bit_reg <= '0;
        r_cnt_reg <= '0;
      end else if (!rx_bit && r_ones_reg == `LLF_STUFF_ONES) begin
        r_bit_reg <= r_bit_reg;                               // stuffed zero dropped
      end else if (r_in_reg) begin
        r_sh_reg  <= {rx_bit, r_sh_reg[7:1]};
        r_bit_reg <= r_bit_reg + 1'b1;
        if (r_bit_reg == 3'h7) begin
          if (r_cnt_reg == 2'h0) r_adr_reg <= {rx_bit, r_sh_reg[7:1]};
          if (r_cnt_reg == 2'h1) r_ctl_reg <= {rx_bit, r_sh_reg[7:1]};
          if (r_cnt_reg != 2'h3) r_cnt_reg <= r_cnt_reg + 1'b1;
        end
      end
    end
  end

  // accepted frame results
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rxc_reg   <= '0;
      rxcmd_reg <= 1'b0;
      rxok_reg  <= 1'b0;
    end else if (rx_end_ok) begin
      rxc_reg   <= r_ctl_reg;
      rxcmd_reg <= a_rem;                                     // RULE4
      rxok_reg  <= 1'b1;
    end
  end

  // read port and status outputs, all registered
  logic [7:0] stat;
  assign stat = {rxok_reg, ~fifo_val, ~fifo_rdy, rxabt_reg, rxcmd_reg, err_reg, rt_run_reg,
                 tx_st_reg != TX_IDLE};
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_OUT   <= '0;
      DATA_OE    <= 1'b0;
      LINK_ERROR <= 1'b0;
      TX_BUSY    <= 1'b0;
    end else begin
      DATA_OE    <= ~cs_n_s & ~re_n_s;
      LINK_ERROR <= err_reg;
      TX_BUSY    <= tx_st_reg != TX_IDLE;
      case (adr_s)
        `LLF_OFS_CTRL:   DATA_OUT <= ctrl_reg;
        `LLF_OFS_STAT:   DATA_OUT <= stat;
        `LLF_OFS_SEQ:    DATA_OUT <= seq_reg;
        `LLF_OFS_TXLEN:  DATA_OUT <= txlen_reg;
        `LLF_OFS_RXCTRL: DATA_OUT <= rxc_reg;
        `LLF_OFS_TMR_LO: DATA_OUT <= tmr_lo_reg;
        `LLF_OFS_TMR_HI: DATA_OUT <= tmr_hi_reg;
        `LLF_OFS_LADDR:  DATA_OUT <= laddr_reg;
        `LLF_OFS_RADDR:  DATA_OUT <= raddr_reg;
        default:         DATA_OUT <= 8'h00;                   // unmapped reads zero
      endcase
    end
  end
endmodule
`default_nettype wire

// ### llf_link_frame_control_assertions.sv
// port-level checker for the lapb link frame control block
`timescale 1ns/100ps
`default_nettype none

module llf_link_frame_control_assertions (
  input wire logic CLOCK,          // system clock
  input wire logic RESET_N,        // async reset, low
  input wire logic CS_N,           // chip select pin
  input wire logic RE_N,           // read strobe pin
  input wire logic DATA_OE,        // read drive enable
  input wire logic TX_BIT_CLOCK,   // transmit bit clock pin
  input wire logic SERIAL_TX_DATA, // transmit line
  input wire logic LINK_ERROR,     // retries exhausted
  input wire logic TX_BUSY         // framer active
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // read data is only driven after a select and read strobe three clocks back
  a_oe_needs_read: assert property (DATA_OE |-> $past(!CS_N && !RE_N, 3)) else $error("drive without read");
  a_oe_read_drop: assert property ($rose(RE_N) |-> ##[1:4] !DATA_OE) else $error("drive held");
  // line moves only after a falling bit clock, the sync lag allows two clocks
  a_tx_after_fall: assert property ($changed(SERIAL_TX_DATA) |-> $past(!TX_BIT_CLOCK, 2)) else $error("bit moved");
  a_busy_on_fall: assert property ($rose(TX_BUSY) |-> $past(!TX_BIT_CLOCK, 2)) else $error("start off edge");
  a_flag_opens: assert property ($rose(TX_BUSY) |-> ##[0:12] !SERIAL_TX_DATA) else $error("no opening flag");
  a_frame_min_len: assert property ($rose(TX_BUSY) |=> TX_BUSY[*8]) else $error("frame too short");
  a_err_then_send: assert property ($rose(LINK_ERROR) |-> ##[0:300] TX_BUSY) else $error("no reset frame");
  // sticky: only a host write may clear the error, so no select means no drop
  a_err_sticky: assert property ((CS_N[*6] ##0 LINK_ERROR) |=> LINK_ERROR) else $error("error dropped");
  c_frame: cover property ($rose(TX_BUSY));
  c_error: cover property ($rose(LINK_ERROR));
  c_read: cover property ($rose(DATA_OE));
endmodule

bind llf_link_frame_control llf_link_frame_control_assertions llf_link_frame_control_assertions_i (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .CS_N(CS_N), .RE_N(RE_N), .DATA_OE(DATA_OE), .TX_BIT_CLOCK(TX_BIT_CLOCK),
  .SERIAL_TX_DATA(SERIAL_TX_DATA), .LINK_ERROR(LINK_ERROR), .TX_BUSY(TX_BUSY));
`default_nettype wire

// ### llf_remote_station.sv
// remote station model: sends short frames on the receive line
`timescale 1ns/100ps
`default_nettype none

module llf_remote_station (
  input  wire logic tx_data, // device transmit line, watched only
  output logic      rx_clk,  // bit clock, still between frames
  output logic      rx_data  // bit line toward the device
);
  initial begin
    rx_clk = 1'b0;
    rx_data = 1'b1;
  end
  // one bit per 400 ns, data set while the clock is low
  task automatic bit_out(input logic b);
    rx_data = b;
    #200 rx_clk = 1'b1;
    #200 rx_clk = 1'b0;
  endtask
  // flag, address, control, then flag or abort run
  task automatic send(input logic [7:0] a, input logic [7:0] c, input logic abt);
    logic [31:0] w; // whole frame, lsb first
    int          ones; // run of ones inside the fields
    w = {abt ? 8'hff : 8'h7e, c, a, 8'h7e};
    ones = 0;
    #7;
    for (int i = 0; i < 32; i++) begin
      bit_out(w[i]);
      ones = (w[i] && i > 7 && i < 24) ? ones + 1 : 0;
      if (ones == 5) begin // zero insertion keeps flags unique
        bit_out(1'b0);
        ones = 0;
      end
    end
    rx_data = ~rx_data; // released line shows no stale value
  endtask
endmodule
`default_nettype wire

// ### llf_link_frame_control_tb_top.sv
// testbench top for the lapb link frame control block
`timescale 1ns/100ps
`default_nettype none

module llf_link_frame_control_tb_top;
  logic        clock, reset_n, cs_n, re_n, we_n, tx_clk, rx_clk, rx_data, oe, oe_q, txd, link_err, busy;
  logic [3:0]  addr;       // register address
  logic [7:0]  din, dout, r; // bus data and a random byte
  logic [15:0] exp_q[$];   // {mask, value} per read
  logic [15:0] w;          // popped note
  int          failures, compares;
  always #25 clock = ~clock;
  always #200 tx_clk = ~tx_clk; // free-running transmit bit clock
  llf_link_frame_control #(.TICK_CLKS(4)) llf_link_frame_control_i (.CLOCK(clock), .RESET_N(reset_n),
    .CS_N(cs_n), .RE_N(re_n), .WE_N(we_n), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
    .TX_BIT_CLOCK(tx_clk), .RX_BIT_CLOCK(rx_clk), .SERIAL_RX_DATA(rx_data), .SERIAL_TX_DATA(txd),
    .LINK_ERROR(link_err), .TX_BUSY(busy));
  llf_remote_station llf_remote_station_i (.tx_data(txd), .rx_clk(rx_clk), .rx_data(rx_data));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // strobes outlast the sync lag
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    {cs_n, we_n, addr, din} = {2'b00, a, d};
    repeat (4) @(negedge clock);
    we_n = 1'b1;
    repeat (8) @(negedge clock);
    cs_n = 1'b1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge clock);
    {cs_n, re_n, addr} = {2'b00, a};
    exp_q.push_back({m, e & m});
    repeat (5) @(negedge clock);
    {cs_n, re_n} = 2'b11;
    repeat (5) @(negedge clock);
  endtask
  task automatic wait_on(input logic err, input logic b);
    for (int n = 0; n < 40000; n++) begin
      @(negedge clock);
      if (err ? link_err === 1'b1 : busy === b) return;
    end
    failures++;
    test_done();
  endtask
  // read data taken as oe rises
  always @(negedge clock) begin
    oe_q <= oe;
    if (oe === 1'b1 && oe_q !== 1'b1 && exp_q.size() > 0) begin
      w = exp_q.pop_front();
      check(dout & w[15:8], w[7:0]);
    end
  end
  initial begin
    {clock, reset_n, cs_n, re_n, we_n, tx_clk, oe_q, addr, din} = {7'b0011100, 4'h0, 8'h00};
    {failures, compares} = 0;
    void'($urandom(49058));
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    r = 8'($urandom);
    rd(4'he, 8'hff, 8'h00);
    wr(4'he, r);
    wr(4'hf, ~r);
    rd(4'he, 8'hff, r);
    rd(4'hf, 8'hff, ~r);
    rd(4'h5, 8'hff, 8'h00);
    wr(4'he, 8'h01);
    wr(4'hf, 8'h03);
    llf_remote_station_i.send(8'h03, 8'h21, 1'b0);
    rd(4'h7, 8'hff, 8'h21);
    rd(4'h1, 8'h88, 8'h88);
    llf_remote_station_i.send(8'h01, 8'h73, 1'b0);
    rd(4'h7, 8'hff, 8'h73);
    rd(4'h1, 8'h88, 8'h80);
    llf_remote_station_i.send(8'h55, 8'h0f, 1'b0);
    llf_remote_station_i.send(8'h03, 8'h3f, 1'b1);
    rd(4'h7, 8'hff, 8'h73);
    rd(4'h1, 8'h10, 8'h10);
    wr(4'h8, 8'hff);
    wr(4'h9, 8'h07);
    wr(4'hf, 8'h01);
    wr(4'h0, 8'h99);
    wait_on(1'b0, 1'b1);
    wait_on(1'b0, 1'b0);
    rd(4'h7, 8'hff, 8'h11);
    wr(4'hf, 8'h03);
    wr(4'h0, 8'h00);
    for (int i = 0; i < 33; i++) wr(4'h2, 8'($urandom));
    rd(4'h1, 8'h20, 8'h20);
    wr(4'h4, 8'h20);
    wr(4'h0, 8'h01);
    wait_on(1'b0, 1'b1);
    wait_on(1'b0, 1'b0);
    rd(4'h1, 8'h40, 8'h40);
    wait_on(1'b1, 1'b0);
    check({7'h00, link_err}, 8'h01);
    wait_on(1'b0, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
